// *** hw/motor_ctrl_defs.vh ***
`ifndef MOTOR_CTRL_DEFS_VH
`define MOTOR_CTRL_DEFS_VH

// ****************************************
// Clock and time bases
// ****************************************
`define CLK_HZ             10000000
`define CLK_PERIOD_NS      100
`define MS_TO_CYC(ms)      ((ms) * (`CLK_HZ / 1000))

// ****************************************
// Protection timing (ms)
// ****************************************
`define RELEASE_TIME_MS    2000
`define UV_DELAY_MS        1200
`define OT1_DELAY_MS       16
`define OT2_DELAY_MS       500
`define OC1_DELAY_MS       10
`define OC2_DELAY_MS       10
`define OC3_DELAY_MS       10
`define STALL_DELAY_MS     10

// ****************************************
// Lamp and display timing
// ****************************************
`define LAMP_HOLD_MS       32000
`define SOC_HOLD_MS        2000
`define ALARM_HALF_MS      250
`define SOC_REFRESH_MS     100

// ****************************************
// Duty scale and thresholds (8-bit codes)
// ****************************************
`define DUTY_FULL          8'hff
`define DUTY_SNAP          8'hf3
`define MIN_DUTY           8'h20
`define UV_LEVEL           8'h60
`define SOC_LEVEL1         8'h80
`define SOC_LEVEL2         8'ha0
`define SOC_LEVEL3         8'hc0
`define OC1_LEVEL          8'h80
`define OC2_LEVEL          8'ha0
`define OC3_LEVEL          8'hc0
`define STALL_LEVEL        8'he0

// ****************************************
// Soft-start step wait choices (cycles)
// ****************************************
`define SS_WAIT_0          16'd2500
`define SS_WAIT_1          16'd10000
`define SS_WAIT_2          16'd20000
`define SS_WAIT_3          16'd40000

`endif

// *** hw/fault_timer.v ***
`timescale 1ns/1ps
// Counts uninterrupted fault time; trips when it exceeds the delay
module fault_timer #(
    parameter DELAY = 100
) (
    // Clock and reset
    input  wire mclk,
    input  wire rst_b,
    // Condition and result
    input  wire active,
    output reg  trip
);
    reg [31:0] count;

    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            count <= 32'h0;
            trip  <= 1'b0;
        end else if (!active) begin
            count <= 32'h0;
            trip  <= 1'b0;
        end else if (count >= DELAY) begin
            trip <= 1'b1;
        end else begin
            count <= count + 32'h1;
        end
    end
endmodule

// *** hw/motor_pwm_protect_ctrl.v ***
`timescale 1ns/1ps
`include "motor_ctrl_defs.vh"

module motor_pwm_protect_ctrl #(
    parameter PWM_PERIOD  = 5000,
    parameter MIN_DUTY    = `MIN_DUTY,
    parameter RELEASE_CYC = `MS_TO_CYC(`RELEASE_TIME_MS),
    parameter UV_CYC      = `MS_TO_CYC(`UV_DELAY_MS),
    parameter OT1_CYC     = `MS_TO_CYC(`OT1_DELAY_MS),
    parameter OT2_CYC     = `MS_TO_CYC(`OT2_DELAY_MS),
    parameter OC1_CYC     = `MS_TO_CYC(`OC1_DELAY_MS),
    parameter OC2_CYC     = `MS_TO_CYC(`OC2_DELAY_MS),
    parameter OC3_CYC     = `MS_TO_CYC(`OC3_DELAY_MS),
    parameter STALL_CYC   = `MS_TO_CYC(`STALL_DELAY_MS),
    parameter LAMP_CYC    = `MS_TO_CYC(`LAMP_HOLD_MS),
    parameter SOC_CYC     = `MS_TO_CYC(`SOC_HOLD_MS),
    parameter ALARM_CYC   = `MS_TO_CYC(`ALARM_HALF_MS),
    parameter REFRESH_CYC = `MS_TO_CYC(`SOC_REFRESH_MS)
) (
    // Clock and reset
    input  wire       mclk,
    input  wire       rst_b,
    // Trigger switch pin
    input  wire       trigger,
    // Digitised analog measurements
    input  wire [7:0] speed_control_voltage,
    input  wire [7:0] battery_level,
    input  wire [7:0] sense_current,
    // Comparator pins
    input  wire       cell_low,
    input  wire       thermistor_one_hot,
    input  wire       thermistor_two_hot,
    input  wire       thermistor_two_cold,
    // Configuration
    input  wire [1:0] ramp_select,
    // Motor and lamp drive
    output reg        pwm_out,
    output reg        lamp_drive,
    // Charge display
    output reg  [2:0] charge_led,
    // Status
    output reg        protect_active,
    output reg  [6:0] fault_cause
);
    localparam ST_STANDBY = 2'd0;
    localparam ST_ACTIVE  = 2'd1;
    localparam ST_ALERT   = 2'd2;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    reg [2:0] sync_trig;
    reg [2:0] sync_low;
    reg [2:0] sync_oh1;
    reg [2:0] sync_oh2;
    reg [2:0] sync_uc2;
    reg       trig;
    reg       low;
    reg       oh1;
    reg       oh2;
    reg       uc2;

    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            sync_trig <= 3'h0;
            sync_low  <= 3'h0;
            sync_oh1  <= 3'h0;
            sync_oh2  <= 3'h0;
            sync_uc2  <= 3'h0;
            trig      <= 1'b0;
            low       <= 1'b0;
            oh1       <= 1'b0;
            oh2       <= 1'b0;
            uc2       <= 1'b0;
        end else begin
            sync_trig <= {sync_trig[1:0], trigger};
            sync_low  <= {sync_low[1:0], cell_low};
            sync_oh1  <= {sync_oh1[1:0], thermistor_one_hot};
            sync_oh2  <= {sync_oh2[1:0], thermistor_two_hot};
            sync_uc2  <= {sync_uc2[1:0], thermistor_two_cold};
            if (sync_trig[1] == sync_trig[2])
                trig <= sync_trig[2];
            if (sync_low[1] == sync_low[2])
                low <= sync_low[2];
            if (sync_oh1[1] == sync_oh1[2])
                oh1 <= sync_oh1[2];
            if (sync_oh2[1] == sync_oh2[2])
                oh2 <= sync_oh2[2];
            if (sync_uc2[1] == sync_uc2[2])
                uc2 <= sync_uc2[2];
        end
    end

    // ****************************************
    // Duty demand and compensated current
    // ****************************************
    reg  [7:0] duty;
    wire [7:0] floor_duty = MIN_DUTY;
    reg  [7:0] demand;
    reg  [7:0] avg_current;
    reg  [15:0] prod;

    always @* begin
        if (speed_control_voltage >= `DUTY_SNAP)
            demand = `DUTY_FULL;
        else if (speed_control_voltage < floor_duty)
            demand = floor_duty;
        else
            demand = speed_control_voltage;
    end

    // Average current = sense peak scaled by duty
    always @* begin
        prod = sense_current * duty;
    end

    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b)
            avg_current <= 8'h0;
        else if (pwm_out)
            avg_current <= prod[15:8];
    end

    // ****************************************
    // Fault detection timers
    // ****************************************
    wire [6:0] trips;
    wire [6:0] conds;
    wire [7:0] oc_levels [0:3];
    reg  [1:0] state;
    wire       run = (state == ST_ACTIVE);

    assign oc_levels[0] = `OC1_LEVEL;
    assign oc_levels[1] = `OC2_LEVEL;
    assign oc_levels[2] = `OC3_LEVEL;
    assign oc_levels[3] = `STALL_LEVEL;
    assign conds[4] = low;
    assign conds[5] = oh1 & run;
    assign conds[6] = (oh2 | uc2) & run;

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : oc_gen
            assign conds[g] = run & (avg_current > oc_levels[g]);
            fault_timer #(
                .DELAY (g == 0 ? OC1_CYC : g == 1 ? OC2_CYC : g == 2 ? OC3_CYC : STALL_CYC)
            ) u_oc (
                .mclk   (mclk),
                .rst_b  (rst_b),
                .active (conds[g]),
                .trip   (trips[g])
            );
        end
    endgenerate

    fault_timer #(.DELAY(UV_CYC)) u_uv (
        .mclk   (mclk),
        .rst_b  (rst_b),
        .active (conds[4]),
        .trip   (trips[4])
    );
    fault_timer #(.DELAY(OT1_CYC)) u_ot1 (
        .mclk   (mclk),
        .rst_b  (rst_b),
        .active (conds[5]),
        .trip   (trips[5])
    );
    fault_timer #(.DELAY(OT2_CYC)) u_ot2 (
        .mclk   (mclk),
        .rst_b  (rst_b),
        .active (conds[6]),
        .trip   (trips[6])
    );

    // ****************************************
    // Operating state and release timer
    // ****************************************
    reg [31:0] release_count;
    wire       released = (release_count >= RELEASE_CYC);

    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b)
            release_count <= 32'h0;
        else if (trig || state != ST_ALERT)
            release_count <= 32'h0;
        else if (!released)
            release_count <= release_count + 32'h1;
    end

    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state          <= ST_STANDBY;
            fault_cause    <= 7'h0;
            protect_active <= 1'b0;
        end else begin
            case (state)
                ST_STANDBY: begin
                    if (trips[4]) begin
                        state       <= ST_ALERT;
                        fault_cause <= 7'h10;
                    end else if (trig)
                        state <= ST_ACTIVE;
                end
                ST_ACTIVE: begin
                    if (trips != 7'h0) begin
                        state       <= ST_ALERT;
                        fault_cause <= trips;
                    end else if (!trig)
                        state <= ST_STANDBY;
                end
                ST_ALERT: begin
                    // Undervoltage also needs battery recovered
                    if (released && !(fault_cause[4] && low)) begin
                        state       <= ST_STANDBY;
                        fault_cause <= 7'h0;
                    end
                end
                default: state <= ST_STANDBY;
            endcase
            protect_active <= (state == ST_ALERT);
        end
    end

    // ****************************************
    // Soft start and PWM generation
    // ****************************************
    reg [15:0] ss_count;
    reg [15:0] ss_wait;
    reg [31:0] pwm_count;
    wire [31:0] on_time = (PWM_PERIOD * duty) / 256;

    always @* begin
        case (ramp_select)
            2'd0:    ss_wait = `SS_WAIT_0;
            2'd1:    ss_wait = `SS_WAIT_1;
            2'd2:    ss_wait = `SS_WAIT_2;
            default: ss_wait = `SS_WAIT_3;
        endcase
    end

    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            duty     <= 8'h0;
            ss_count <= 16'h0;
        end else if (!run) begin
            duty     <= floor_duty;
            ss_count <= 16'h0;
        end else if (duty > demand || demand == `DUTY_FULL && duty >= `DUTY_SNAP) begin
            duty     <= demand;
            ss_count <= 16'h0;
        end else if (duty < demand) begin
            if (ss_count >= ss_wait) begin
                ss_count <= 16'h0;
                duty     <= duty + 8'h01;
            end else
                ss_count <= ss_count + 16'h1;
        end
    end

    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pwm_count <= 32'h0;
            pwm_out   <= 1'b0;
        end else begin
            if (pwm_count >= PWM_PERIOD - 1)
                pwm_count <= 32'h0;
            else
                pwm_count <= pwm_count + 32'h1;
            if (!run || trips != 7'h0)
                pwm_out <= 1'b0;
            else if (duty == `DUTY_FULL)
                pwm_out <= 1'b1;
            else
                pwm_out <= (pwm_count < on_time);
        end
    end

    // ****************************************
    // Lamp and alarm flashing
    // ****************************************
    reg [31:0] lamp_count;
    reg [31:0] flash_count;
    reg        flash;

    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            lamp_count  <= 32'h0;
            flash_count <= 32'h0;
            flash       <= 1'b0;
            lamp_drive  <= 1'b0;
        end else begin
            if (trig)
                lamp_count <= LAMP_CYC;
            else if (lamp_count != 32'h0)
                lamp_count <= lamp_count - 32'h1;
            if (state != ST_ALERT) begin
                flash_count <= 32'h0;
                flash       <= 1'b1;
            end else if (flash_count >= ALARM_CYC - 1) begin
                flash_count <= 32'h0;
                flash       <= ~flash;
            end else
                flash_count <= flash_count + 32'h1;
            if (state == ST_ALERT)
                lamp_drive <= flash;
            else
                lamp_drive <= trig | (lamp_count != 32'h0);
        end
    end

    // ****************************************
    // Charge level and display
    // ****************************************
    reg [31:0] refresh_count;
    reg [31:0] soc_count;
    reg [2:0]  soc_level;
    reg        trig_d;

    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            refresh_count <= 32'h0;
            soc_level     <= 3'h0;
            soc_count     <= 32'h0;
            trig_d        <= 1'b0;
            charge_led    <= 3'h0;
        end else begin
            trig_d <= trig;
            if (refresh_count >= REFRESH_CYC - 1) begin
                refresh_count <= 32'h0;
                if (state == ST_STANDBY)
                    soc_level <= {battery_level >= `SOC_LEVEL3, battery_level >= `SOC_LEVEL2,
                                  battery_level >= `SOC_LEVEL1};
            end else
                refresh_count <= refresh_count + 32'h1;
            if (trig && !trig_d)
                soc_count <= SOC_CYC;
            else if (soc_count != 32'h0)
                soc_count <= soc_count - 32'h1;
            charge_led <= (soc_count != 32'h0) ? soc_level : 3'h0;
        end
    end
endmodule

// *** test/motor_pwm_protect_ctrl_monitor.sv ***
`timescale 1ns/1ps
module motor_pwm_protect_ctrl_monitor #(
    parameter UV_CYC      = 100,
    parameter OT1_CYC     = 50,
    parameter OT2_CYC     = 50,
    parameter RELEASE_CYC = 200
) (
    // Clock and reset
    input wire       mclk,
    input wire       rst_b,
    // Inputs
    input wire       trigger,
    input wire       cell_low,
    input wire       thermistor_one_hot,
    input wire       thermistor_two_hot,
    input wire       thermistor_two_cold,
    // Outputs
    input wire       pwm_out,
    input wire       lamp_drive,
    input wire [2:0] charge_led,
    input wire       protect_active,
    input wire [6:0] fault_cause
);
    // ****************************************
    // Uninterrupted condition counters
    // ****************************************
    logic [15:0] cl_cnt;
    logic [15:0] t1_cnt;
    logic [15:0] t2_cnt;
    logic [15:0] rel_cnt;
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cl_cnt  <= 16'h0000;
            t1_cnt  <= 16'h0000;
            t2_cnt  <= 16'h0000;
            rel_cnt <= 16'h0000;
        end else begin
            cl_cnt  <= cell_low ? cl_cnt + 16'h0001 : 16'h0000;
            t1_cnt  <= thermistor_one_hot ? t1_cnt + 16'h0001 : 16'h0000;
            t2_cnt  <= (thermistor_two_hot | thermistor_two_cold) ? t2_cnt + 16'h0001 : 16'h0000;
            rel_cnt <= trigger ? 16'h0000 : rel_cnt + 16'h0001;
        end
    end
    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    sequence s_trip;
        $rose(|fault_cause);
    endsequence
    sequence s_cut;
        !pwm_out[*8];
    endsequence
    sequence s_flip;
        protect_active && $changed(lamp_drive);
    endsequence
    a_trip_cuts_pwm: assert property (s_trip |=> s_cut)
        else $error("pwm high after trip");
    a_alert_pwm_low: assert property (protect_active |-> !pwm_out)
        else $error("pwm high in alert");
    a_cause_held: assert property (fault_cause != 7'h00 && $past(fault_cause) != 7'h00 |-> $stable(fault_cause))
        else $error("fault cause changed in alert");
    a_uv_delay: assert property ($rose(fault_cause[4]) |-> cl_cnt >= UV_CYC)
        else $error("undervoltage trip too early");
    a_temp_delay: assert property ($rose(fault_cause[5]) |-> t1_cnt >= OT1_CYC)
        else $error("temperature one trip too early");
    a_temp2_delay: assert property ($rose(fault_cause[6]) |-> t2_cnt >= OT2_CYC)
        else $error("temperature two trip too early");
    a_release_exit: assert property ($fell(protect_active) |-> rel_cnt >= RELEASE_CYC)
        else $error("alert left before release time");
    a_alarm_period: assert property (s_flip ##1 protect_active[*8] |-> lamp_drive == $past(lamp_drive, 8))
        else $error("alarm toggles too fast");
    a_alarm_flashes: assert property (s_flip |-> ##[1:25] ($changed(lamp_drive) || !protect_active))
        else $error("alarm stopped flashing");
    a_lamp_follows: assert property ((trigger && !protect_active && fault_cause == 7'h00)[*6] |-> lamp_drive)
        else $error("lamp off while pressed");
    a_led_gauge: assert property (charge_led inside {3'h0, 3'h1, 3'h3, 3'h7})
        else $error("charge leds not a gauge");
    a_min_pulse: assert property ($rose(pwm_out) |-> (pwm_out && fault_cause == 7'h00)[*6] or ##[0:6] (fault_cause != 7'h00 || rel_cnt != 16'h0000))
        else $error("pwm pulse below minimum");
endmodule
bind motor_pwm_protect_ctrl motor_pwm_protect_ctrl_monitor #(
    .UV_CYC(UV_CYC), .OT1_CYC(OT1_CYC), .OT2_CYC(OT2_CYC), .RELEASE_CYC(RELEASE_CYC)
) mon (
    .mclk(mclk), .rst_b(rst_b), .trigger(trigger), .cell_low(cell_low),
    .thermistor_one_hot(thermistor_one_hot), .thermistor_two_hot(thermistor_two_hot),
    .thermistor_two_cold(thermistor_two_cold), .pwm_out(pwm_out), .lamp_drive(lamp_drive),
    .charge_led(charge_led), .protect_active(protect_active), .fault_cause(fault_cause)
);

// *** test/motor_far_side.sv ***
`timescale 1ns/1ps
module motor_far_side (
    // Bench side
    input  wire       press,
    input  wire [7:0] load,
    // Block side
    input  wire       pwm_out,
    output wire       trigger,
    output wire [7:0] sense_current
);
    assign trigger = press;
    // Sense resistor carries current only while the switch conducts
    assign sense_current = pwm_out ? load : 8'h00;
endmodule

// *** test/motor_pwm_protect_ctrl_bench.sv ***
`timescale 1ns/1ps
module motor_pwm_protect_ctrl_bench;
    reg        mclk = 1'b0;
    reg        rst_b = 1'b0;
    reg        press;
    reg  [7:0] speed;
    reg  [7:0] batt;
    reg  [7:0] load;
    reg        cell_low;
    reg  [2:0] tpin;
    reg  [1:0] ramp_select;
    wire       trigger;
    wire [7:0] sense_current;
    wire       pwm_out;
    wire       lamp_drive;
    wire [2:0] charge_led;
    wire       protect_active;
    wire [6:0] fault_cause;
    int        err_total = 0;
    int        total_checks = 0;
    always #50 mclk = ~mclk;
    motor_pwm_protect_ctrl #(
        .PWM_PERIOD(50), .RELEASE_CYC(200), .UV_CYC(100), .OT1_CYC(50), .OT2_CYC(50),
        .OC1_CYC(20), .OC2_CYC(20), .OC3_CYC(20), .STALL_CYC(20), .LAMP_CYC(300),
        .SOC_CYC(200), .ALARM_CYC(20), .REFRESH_CYC(10)
    ) dut (
        .mclk(mclk), .rst_b(rst_b), .trigger(trigger), .speed_control_voltage(speed),
        .battery_level(batt), .sense_current(sense_current), .cell_low(cell_low),
        .thermistor_one_hot(tpin[0]), .thermistor_two_hot(tpin[1]), .thermistor_two_cold(tpin[2]),
        .ramp_select(ramp_select), .pwm_out(pwm_out), .lamp_drive(lamp_drive),
        .charge_led(charge_led), .protect_active(protect_active), .fault_cause(fault_cause)
    );
    motor_far_side far (
        .press(press), .load(load), .pwm_out(pwm_out), .trigger(trigger), .sense_current(sense_current)
    );
    // ****************************************
    // Helpers
    // ****************************************
    task cyc(input int n);
        repeat (n) @(posedge mclk);
        #5;
    endtask
    task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task give_verdict;
        if (err_total == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task on_time(output logic [7:0] n);
        n = 8'h00;
        repeat (50) begin
            @(posedge mclk);
            if (pwm_out === 1'b1) n = n + 8'h01;
        end
        #5;
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task t_leds;
        for (int i = 0; i < 4; i++) begin
            batt = 8'h70 + 8'h20 * i;
            cyc(30);
            press = 1'b1;
            cyc(8);
            chk("gauge shown", (8'h01 << i) - 8'h01, charge_led);
            press = 1'b0;
            cyc(150);
            chk("gauge held", (8'h01 << i) - 8'h01, charge_led);
            cyc(80);
            chk("gauge off", 8'h00, charge_led);
        end
    endtask
    task t_lamp;
        press = 1'b1;
        cyc(10);
        chk("lamp on", 8'h01, lamp_drive);
        press = 1'b0;
        cyc(290);
        chk("lamp hold", 8'h01, lamp_drive);
        cyc(25);
        chk("lamp off", 8'h00, lamp_drive);
    endtask
    task t_duty;
        logic [7:0] n;
        speed = 8'h00;
        press = 1'b1;
        cyc(120);
        on_time(n);
        chk("floor duty", 8'h06, n);
        press = 1'b0;
        cyc(60);
        on_time(n);
        chk("idle duty", 8'h00, n);
        speed = 8'h40;
        press = 1'b1;
        cyc(17500);
        on_time(n);
        chk("ramp duty", 8'h07, n);
        press = 1'b0;
        cyc(60);
        ramp_select = 2'h1;
        load = 8'h80;
        press = 1'b1;
        cyc(17500);
        on_time(n);
        chk("slow ramp duty", 8'h06, n);
        press = 1'b0;
        ramp_select = 2'h0;
        load = 8'hff;
        cyc(60);
    endtask
    task t_temp;
        for (int i = 0; i < 3; i++) begin
            speed = 8'h20;
            press = 1'b1;
            cyc(10);
            tpin[i] = 1'b1;
            cyc(30);
            tpin[i] = 1'b0;
            cyc(5);
            tpin[i] = 1'b1;
            cyc(30);
            chk("no early trip", 8'h00, fault_cause);
            cyc(40);
            chk("temp cause", (i == 0) ? 8'h20 : 8'h40, fault_cause);
            chk("alert on", 8'h01, protect_active);
            chk("pwm cut", 8'h00, pwm_out);
            tpin[i] = 1'b0;
            press = 1'b0;
            cyc(100);
            press = 1'b1;
            cyc(5);
            press = 1'b0;
            cyc(150);
            chk("alert kept", 8'h01, protect_active);
            cyc(70);
            chk("alert left", 8'h00, protect_active);
            chk("cause clear", 8'h00, fault_cause);
        end
    endtask
    task t_uv;
        press = 1'b0;
        cell_low = 1'b1;
        cyc(130);
        chk("uv cause", 8'h10, fault_cause);
        chk("uv alert", 8'h01, protect_active);
        cyc(250);
        chk("uv kept", 8'h01, protect_active);
        cell_low = 1'b0;
        cyc(15);
        chk("uv left", 8'h00, protect_active);
    endtask
    // ****************************************
    // Main sequence and watchdog
    // ****************************************
    initial begin
        press = 1'b0;
        speed = 8'h00;
        batt = 8'h00;
        load = 8'hff;
        cell_low = 1'b0;
        tpin = 3'h0;
        ramp_select = 2'h0;
        repeat (20) @(posedge mclk);
        #5;
        rst_b = 1'b1;
        cyc(5);
        t_leds;
        t_lamp;
        t_duty;
        t_temp;
        t_uv;
        give_verdict;
    end
    initial begin
        repeat (60000) @(posedge mclk);
        err_total++;
        give_verdict;
    end
endmodule
